// ===== hdl/mbsd_pkg.sv
// package for the slot address decoder: function codes, area bases, reference bands,
// slot classes and exception codes.
// assumes one request element per access; an upstream framer splits quantities.
package mbsd_pkg;
  localparam int NSLOT = 51;
  // function codes
  localparam logic [7:0] FC_RD_COIL = 8'h01;
  localparam logic [7:0] FC_RD_DIN = 8'h02;
  localparam logic [7:0] FC_RD_HREG = 8'h03;
  localparam logic [7:0] FC_RD_IREG = 8'h04;
  localparam logic [7:0] FC_WR_COIL = 8'h05;
  localparam logic [7:0] FC_WR_HREG = 8'h06;
  localparam logic [7:0] FC_DIAG = 8'h08;
  localparam logic [7:0] FC_WR_COILS = 8'h0f;
  localparam logic [7:0] FC_WR_HREGS = 8'h10;
  // exception codes
  localparam logic [7:0] EXC_NONE = 8'h00;
  localparam logic [7:0] EXC_FUNC = 8'h01;
  localparam logic [7:0] EXC_ADDR = 8'h02;
  // direct area bases
  localparam logic [15:0] ADDR_MAX = 16'hffff;
  localparam logic [15:0] BASE_ALLOC = 16'h0000;
  localparam logic [15:0] BASE_SLOT8 = 16'h0400;
  localparam logic [15:0] BASE_STAT = 16'h0800;
  localparam logic [15:0] BASE_SLOT16 = 16'h1400;
  // reference bands and area bases
  localparam logic [15:0] REF_COIL_FIRST = 16'h0001;
  localparam logic [15:0] REF_COIL_LAST = 16'h270f;
  localparam logic [15:0] REF_COIL_SLOT8 = 16'h0bb9;
  localparam logic [15:0] REF_DIN_LO = 16'h2710;
  localparam logic [15:0] REF_DIN_FIRST = 16'h2711;
  localparam logic [15:0] REF_DIN_SLOT8 = 16'h32c9;
  localparam logic [15:0] REF_DIN_STAT = 16'h36b1;
  localparam logic [15:0] REF_DIN_SLOT16 = 16'h3e81;
  localparam logic [15:0] REF_DIN_LAST = 16'h4e1f;
  localparam logic [15:0] REF_IREG_LO = 16'h7530;
  localparam logic [15:0] REF_IREG_LAST = 16'h9c3f;
  localparam logic [15:0] REF_HREG_LO = 16'h9c40;
  localparam logic [15:0] REF_HREG_LAST = 16'hc34f;
  // slot classes
  localparam logic [5:0] SLOT_COM0 = 6'h00;
  localparam logic [5:0] SLOT_IO_LO = 6'h01;
  localparam logic [5:0] SLOT_IO_HI = 6'h30;
  localparam logic [5:0] SLOT_COM1 = 6'h31;
  localparam logic [5:0] SLOT_PSU = 6'h32;
  typedef enum logic [1:0] {TBL_DIN, TBL_COIL, TBL_IREG, TBL_HREG} mbsd_tbl_t;
  typedef enum logic [1:0] {AR_ALLOC, AR_SLOT8, AR_STAT, AR_SLOT16} mbsd_area_t;
  typedef enum logic [1:0] {KIND_COM, KIND_IO, KIND_PSU} mbsd_kind_t;
  // one allocation entry: enable, upper byte of the slot, slot index
  typedef struct packed {
    logic en;
    logic hi;
    logic [5:0] slot;
  } mbsd_alloc_t;
endpackage : mbsd_pkg

// ===== hdl/mbsd_dec_if.sv
// interface between the request core and the address decoder.
// assumes the decoder is purely combinational on the request fields.
`timescale 1ns/1ps
interface mbsd_dec_if;
  import mbsd_pkg::*;
  logic [7:0] fc;
  logic [15:0] addr;
  logic ref_mode;
  logic wr_in;
  mbsd_tbl_t tbl;
  mbsd_area_t area;
  logic wr;
  logic [5:0] slot;
  logic [3:0] ch;
  logic [15:0] offs;
  logic [7:0] exc;
  modport req (output fc, addr, ref_mode, wr_in,
               input tbl, area, wr, slot, ch, offs, exc);
  modport dec (input fc, addr, ref_mode, wr_in,
               output tbl, area, wr, slot, ch, offs, exc);
endinterface : mbsd_dec_if

// ===== hdl/mbsd_decode.sv
// combinational decoder: request code and address to table, area, slot, channel.
// assumes the core resolves allocated areas through its own tables.
`timescale 1ns/1ps
module mbsd_decode #(
  parameter int ALLOC_BYTES = 64
) (
  mbsd_dec_if.dec dif
);
  import mbsd_pkg::*;

  localparam logic [16:0] ALLOC_BITS = 17'(ALLOC_BYTES * 8);

  function automatic logic in_rng(input logic [15:0] v, input logic [15:0] lo,
                                  input logic [15:0] hi);
    return (v >= lo) && (v <= hi);
  endfunction : in_rng

  function automatic logic slot_ok(input logic [12:0] s, input logic [5:0] lo,
                                   input logic [5:0] hi);
    return (s >= {7'h00, lo}) && (s <= {7'h00, hi});
  endfunction : slot_ok

  ////////////////////////////////////////////////////////////////////////////
  // table by code
  wire fc_din = dif.fc == FC_RD_DIN;
  wire fc_ireg = dif.fc == FC_RD_IREG;
  wire fc_wcoil = (dif.fc == FC_WR_COIL) || (dif.fc == FC_WR_COILS);
  wire fc_whreg = (dif.fc == FC_WR_HREG) || (dif.fc == FC_WR_HREGS);
  wire fc_coil = (dif.fc == FC_RD_COIL) || fc_wcoil;
  wire fc_hreg = (dif.fc == FC_RD_HREG) || fc_whreg;
  wire rf_coil = dif.addr <= REF_COIL_LAST; // coil band starts at zero
  wire rf_din = in_rng(dif.addr, REF_DIN_LO, REF_DIN_LAST);
  wire rf_ireg = in_rng(dif.addr, REF_IREG_LO, REF_IREG_LAST);
  wire rf_hreg = in_rng(dif.addr, REF_HREG_LO, REF_HREG_LAST);
  // code decides table in direct mode
  wire is_coil = dif.ref_mode ? rf_coil : fc_coil;
  wire is_din = dif.ref_mode ? rf_din : fc_din;
  wire is_ireg = dif.ref_mode ? rf_ireg : fc_ireg;
  wire is_hreg = dif.ref_mode ? rf_hreg : fc_hreg;
  wire known = is_coil || is_din || is_ireg || is_hreg;
  assign dif.wr = dif.ref_mode ? dif.wr_in : (fc_wcoil || fc_whreg);
  assign dif.tbl = is_coil ? TBL_COIL : is_hreg ? TBL_HREG : is_ireg ? TBL_IREG : TBL_DIN;

  ////////////////////////////////////////////////////////////////////////////
  // area bases differ per mode; the area ranges themselves are shared
  wire [15:0] b_alloc = !dif.ref_mode ? BASE_ALLOC : is_coil ? REF_COIL_FIRST : REF_DIN_FIRST;
  wire [15:0] b_s8 = !dif.ref_mode ? BASE_SLOT8 : is_coil ? REF_COIL_SLOT8 : REF_DIN_SLOT8;
  wire [15:0] b_st = dif.ref_mode ? REF_DIN_STAT : BASE_STAT;
  wire [15:0] b_s16 = dif.ref_mode ? REF_DIN_SLOT16 : BASE_SLOT16;
  assign dif.area = (is_din && dif.addr >= b_s16) ? AR_SLOT16 :
                    (is_din && dif.addr >= b_st) ? AR_STAT :
                    (dif.addr >= b_s8) ? AR_SLOT8 : AR_ALLOC;
  wire [15:0] base = (dif.area == AR_SLOT16) ? b_s16 : (dif.area == AR_STAT) ? b_st :
                     (dif.area == AR_SLOT8) ? b_s8 : b_alloc;
  // below the first reference of a band this wraps high and fails the range
  assign dif.offs = dif.addr - base;

  // upper nibble belongs to the previous slot
  wire [12:0] s8 = dif.offs[15:3] - {12'h000, dif.offs[2]};
  wire [12:0] s_st = dif.offs[15:3];
  wire [12:0] s16 = {1'b0, dif.offs[15:4]};
  wire [12:0] slot_w = (dif.area == AR_SLOT16) ? s16 : (dif.area == AR_STAT) ? s_st : s8;
  assign dif.slot = slot_w[5:0];
  assign dif.ch = (dif.area == AR_SLOT16) ? dif.offs[3:0] : {1'b0, dif.offs[2:0]};

  ////////////////////////////////////////////////////////////////////////////
  // inputs slots 0..50, 1..48 in the wide area; coils 1..48
  wire ok_s8 = is_din ? slot_ok(s8, SLOT_COM0, SLOT_PSU) : slot_ok(s8, SLOT_IO_LO, SLOT_IO_HI);
  wire map_ok = (is_ireg || is_hreg) ? 1'b0 :
                (dif.area == AR_ALLOC) ? ({1'b0, dif.offs} < ALLOC_BITS) :
                (dif.area == AR_SLOT8) ? ok_s8 :
                (dif.area == AR_STAT) ? slot_ok(s_st, SLOT_COM0, SLOT_PSU) :
                slot_ok(s16, SLOT_IO_LO, SLOT_IO_HI);
  assign dif.exc = (!known && dif.ref_mode) ? EXC_ADDR :
                   !known ? EXC_FUNC :
                   (dif.wr && (is_din || is_ireg)) ? EXC_FUNC :
                   !map_ok ? EXC_ADDR : EXC_NONE;
endmodule : mbsd_decode

// ===== hdl/mbsd_core.sv
// top of the slot address decoder: one element per request, answer one cycle later.
// assumes request fields are synchronous to i_clk and held only while i_req_valid.
`timescale 1ns/1ps
module mbsd_core #(
  parameter int ALLOC_BYTES = 64,
  parameter int AW = $clog2(ALLOC_BYTES)
) (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_req_valid,
  input wire logic [7:0] i_req_fc,
  input wire logic [15:0] i_req_addr,
  input wire logic i_req_ref_mode,
  input wire logic i_req_wr,
  input wire logic i_req_wdata,
  input wire logic i_alloc_we,
  input wire logic i_alloc_coil,
  input wire logic [AW-1:0] i_alloc_idx,
  input wire mbsd_pkg::mbsd_alloc_t i_alloc_ent,
  input wire logic [mbsd_pkg::NSLOT-1:0][15:0] i_din,
  input wire logic [mbsd_pkg::NSLOT-1:0][7:0] i_mstat,
  output logic o_rsp_valid,
  output logic [7:0] o_rsp_exc,
  output logic o_rsp_data,
  output mbsd_pkg::mbsd_tbl_t o_rsp_table,
  output logic [5:0] o_rsp_slot,
  output logic [3:0] o_rsp_ch,
  output mbsd_pkg::mbsd_kind_t o_rsp_kind,
  output logic [mbsd_pkg::NSLOT-1:0][15:0] o_coil_img
);
  import mbsd_pkg::*;

  function automatic mbsd_kind_t slot_kind(input logic [5:0] s);
    if (s == SLOT_COM0 || s == SLOT_COM1) begin
      return KIND_COM;
    end else if (s == SLOT_PSU) begin
      return KIND_PSU;
    end
    return KIND_IO;
  endfunction : slot_kind

  mbsd_alloc_t alloc_din_r [ALLOC_BYTES];
  mbsd_alloc_t alloc_coil_r [ALLOC_BYTES];

  ////////////////////////////////////////////////////////////////////////////
  // decoder hookup
  mbsd_dec_if dif ();
  assign dif.fc = i_req_fc;
  assign dif.addr = i_req_addr;
  assign dif.ref_mode = i_req_ref_mode;
  assign dif.wr_in = i_req_wr;

  mbsd_decode #(.ALLOC_BYTES(ALLOC_BYTES)) u_dec (.dif(dif));

  ////////////////////////////////////////////////////////////////////////////
  // allocated area goes through the stored table
  wire [AW-1:0] ai = dif.offs[AW+2:3];
  wire is_alloc = dif.area == AR_ALLOC;
  wire mbsd_alloc_t ent = (dif.tbl == TBL_COIL) ? alloc_coil_r[ai] : alloc_din_r[ai];
  wire [5:0] res_slot = is_alloc ? ent.slot : dif.slot;
  wire [3:0] res_ch = is_alloc ? {ent.hi, dif.ch[2:0]} : dif.ch;
  // an empty or stale entry must not index past the image
  wire alloc_bad = is_alloc && (!ent.en || ent.slot > SLOT_PSU);
  // allocation miss is an unmapped address
  wire [7:0] exc_fin = (dif.exc == EXC_NONE && alloc_bad) ? EXC_ADDR : dif.exc;
  wire ok = exc_fin == EXC_NONE;
  // status bits come from their own image
  wire rd_bit = !ok ? 1'b0 :
                (dif.tbl == TBL_COIL) ? o_coil_img[res_slot][res_ch] :
                (dif.area == AR_STAT) ? i_mstat[res_slot][res_ch[2:0]] :
                i_din[res_slot][res_ch];
  wire do_wr = i_req_valid && ok && dif.wr && (dif.tbl == TBL_COIL);

  ////////////////////////////////////////////////////////////////////////////
  // allocation table store, written by the configuration path
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      for (int i = 0; i < ALLOC_BYTES; i++) begin
        alloc_din_r[i] <= '0;
        alloc_coil_r[i] <= '0;
      end
    end else if (i_alloc_we && i_alloc_coil) begin
      alloc_coil_r[i_alloc_idx] <= i_alloc_ent;
    end else if (i_alloc_we) begin
      alloc_din_r[i_alloc_idx] <= i_alloc_ent;
    end
  end

  // coil image only changes on a clean write
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_coil_img <= '0;
    end else if (do_wr) begin
      o_coil_img[res_slot][res_ch] <= i_req_wdata;
    end
  end

  // answer fields except o_rsp_valid, held until the next request
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_rsp_valid <= 1'b0;
      o_rsp_exc <= EXC_NONE;
      o_rsp_data <= 1'b0;
      o_rsp_table <= TBL_DIN;
      o_rsp_slot <= SLOT_COM0;
      o_rsp_ch <= '0;
      o_rsp_kind <= KIND_COM;
    end else begin
      o_rsp_valid <= i_req_valid;
      if (i_req_valid) begin
        o_rsp_exc <= exc_fin;
        o_rsp_data <= dif.wr ? (ok & i_req_wdata) : rd_bit;
        o_rsp_table <= dif.tbl;
        o_rsp_slot <= ok ? res_slot : SLOT_COM0;
        o_rsp_ch <= ok ? res_ch : '0;
        o_rsp_kind <= slot_kind(ok ? res_slot : SLOT_COM0);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);

  wire [15:0] o8 = i_req_addr - BASE_SLOT8;
  wire [15:0] ost = i_req_addr - BASE_STAT;
  wire [15:0] o16 = i_req_addr - BASE_SLOT16;
  wire dir_din = i_req_valid && !i_req_ref_mode && i_req_fc == FC_RD_DIN;
  wire in_s8 = i_req_addr >= BASE_SLOT8 && i_req_addr < BASE_STAT;

  property p_rd_din;
    dir_din |=> o_rsp_valid && o_rsp_table == TBL_DIN;
  endproperty
  a_rd_din: assert property (p_rd_din) else $error("fc 02 not inputs");

  property p_wr_hreg;
    i_req_valid && !i_req_ref_mode && i_req_fc == FC_WR_HREGS |=> o_rsp_table == TBL_HREG;
  endproperty
  a_wr_hreg: assert property (p_wr_hreg) else $error("fc 16 not holding");

  property p_top_addr;
    i_req_valid && !i_req_ref_mode && i_req_fc == FC_RD_COIL && i_req_addr == ADDR_MAX
      |=> o_rsp_table == TBL_COIL && o_rsp_exc == EXC_ADDR;
  endproperty
  a_top_addr: assert property (p_top_addr) else $error("top address misdecoded");

  property p_ref_din;
    i_req_valid && i_req_ref_mode && i_req_wr && i_req_addr == REF_DIN_SLOT8
      |=> o_rsp_table == TBL_DIN && o_rsp_exc == EXC_FUNC && $stable(o_coil_img);
  endproperty
  a_ref_din: assert property (p_ref_din) else $error("input band write taken");

  property p_kind;
    o_rsp_valid && o_rsp_exc == EXC_NONE && o_rsp_slot == SLOT_PSU |-> o_rsp_kind == KIND_PSU;
  endproperty
  a_kind: assert property (p_kind) else $error("slot 50 not supply");

  property p_s8_lo;
    dir_din && in_s8 && !i_req_addr[2] && o8[15:3] <= {7'h00, SLOT_PSU}
      |=> o_rsp_exc == EXC_NONE && o_rsp_slot == $past(o8[8:3])
      && o_rsp_ch == {1'b0, $past(o8[2:0])};
  endproperty
  a_s8_lo: assert property (p_s8_lo) else $error("low channel slot wrong");

  property p_s8_hi;
    dir_din && in_s8 && i_req_addr[2] && o8[15:3] != '0
      |=> o_rsp_exc != EXC_NONE || o_rsp_slot == $past(o8[8:3]) - SLOT_IO_LO;
  endproperty
  a_s8_hi: assert property (p_s8_hi) else $error("high channel slot wrong");

  property p_stat;
    dir_din && i_req_addr >= BASE_STAT && ost[15:3] <= {7'h00, SLOT_PSU}
      |=> o_rsp_exc == EXC_NONE && o_rsp_slot == $past(ost[8:3]);
  endproperty
  a_stat: assert property (p_stat) else $error("status slot wrong");

  property p_s16_zero;
    dir_din && i_req_addr >= BASE_SLOT16 && o16[15:4] == '0 |=> o_rsp_exc == EXC_ADDR;
  endproperty
  a_s16_zero: assert property (p_s16_zero) else $error("slot 0 wide area mapped");

  property p_coil_wr;
    do_wr |=> o_coil_img[$past(res_slot)][$past(res_ch)] == $past(i_req_wdata);
  endproperty
  a_coil_wr: assert property (p_coil_wr) else $error("coil write lost");

  property p_coil_s0;
    i_req_valid && !i_req_ref_mode && i_req_fc == FC_RD_COIL && in_s8 && o8[15:2] == '0
      |=> o_rsp_exc == EXC_ADDR;
  endproperty
  a_coil_s0: assert property (p_coil_s0) else $error("coil slot 0 mapped");

  property p_diag;
    i_req_valid && !i_req_ref_mode && i_req_fc == FC_DIAG |=> o_rsp_exc == EXC_FUNC ##1 1'b1;
  endproperty
  a_diag: assert property (p_diag) else $error("fc 08 accepted");

  property p_ans;
    i_req_valid |=> o_rsp_valid;
  endproperty
  a_ans: assert property (p_ans) else $error("request not answered");

  // wide area is the only one where the slot index carries four channel bits
  property p_s16;
    dir_din && i_req_addr >= BASE_SLOT16 && o16[15:4] >= {6'h00, SLOT_IO_LO}
      && o16[15:4] <= {6'h00, SLOT_IO_HI}
      |=> o_rsp_exc == EXC_NONE && o_rsp_slot == $past(o16[9:4])
      && o_rsp_ch == $past(o16[3:0]);
  endproperty
  a_s16: assert property (p_s16) else $error("wide area slot wrong");

  property p_kind_com;
    o_rsp_valid && o_rsp_exc == EXC_NONE && o_rsp_slot == SLOT_COM1 |-> o_rsp_kind == KIND_COM;
  endproperty
  a_kind_com: assert property (p_kind_com) else $error("slot 49 not com unit");

  property p_alloc_miss;
    i_req_valid && is_alloc && dif.exc == EXC_NONE && !ent.en |=> o_rsp_exc == EXC_ADDR;
  endproperty
  a_alloc_miss: assert property (p_alloc_miss) else $error("empty entry mapped");

  // a refused element must not leak a slot, a channel or a data bit
  property p_exc_quiet;
    o_rsp_valid && o_rsp_exc != EXC_NONE
      |-> o_rsp_slot == SLOT_COM0 && o_rsp_ch == '0 && !o_rsp_data;
  endproperty
  a_exc_quiet: assert property (p_exc_quiet) else $error("exception carries data");
endmodule : mbsd_core

// ===== testbench/mbsd_master.sv
// master model: presents one request element at a time to the decoder.
// assumes the bench calls req back to back and idle between bursts.
`timescale 1ns/1ps
module mbsd_master (
  input wire logic i_clk,
  output logic o_valid,
  output logic [7:0] o_fc,
  output logic [15:0] o_addr,
  output logic o_ref,
  output logic o_wr,
  output logic o_wdata
);
  // quiet request port until the first element
  initial begin
    o_valid = 1'b0;
    o_fc = 8'h00;
    o_addr = 16'h0000;
    o_ref = 1'b0;
    o_wr = 1'b0;
    o_wdata = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////
  // driven at the falling edge, held across the taking edge
  task automatic req(input logic [7:0] fc, input logic [15:0] a, input logic rm,
                     input logic wr, input logic wd);
    @(negedge i_clk);
    o_valid = 1'b1;
    o_fc = fc;
    o_ref = rm;
    o_addr = a;
    o_wr = wr;
    o_wdata = wd;
    @(posedge i_clk);
  endtask : req
  // released code, address and data flip so nobody can lean on a stale value
  task automatic idle();
    @(negedge i_clk);
    o_valid = 1'b0;
    o_fc = ~o_fc;
    o_addr = ~o_addr;
    o_wdata = ~o_wdata;
  endtask : idle
endmodule : mbsd_master

// ===== testbench/test_modbus_slot_address_decoder.sv
// self-checking bench for the slot address decoder, master model in front.
// assumes every taken element is answered exactly one cycle later.
`timescale 1ns/1ps
module test_modbus_slot_address_decoder;
  import mbsd_pkg::*;
  localparam logic [22:0] M_OK = 23'h7fffff;
  localparam logic [22:0] M_EX = 23'h7ffffc; // kind left open on exceptions
  localparam logic [22:0] M_EF = 23'h7fcffc; // table left open as well
  logic i_clk = 1'b0;
  logic i_rst_b = 1'b0;
  logic i_alloc_we = 1'b0;
  logic i_alloc_coil = 1'b0;
  logic [5:0] i_alloc_idx = 6'h00;
  mbsd_alloc_t i_alloc_ent = '0;
  logic [NSLOT-1:0][15:0] i_din = '0;
  logic [NSLOT-1:0][7:0] i_mstat = '0;
  logic [NSLOT-1:0][15:0] cimg = '0;
  logic [NSLOT-1:0][15:0] o_coil_img;
  logic rq_v, rq_ref, rq_wr, rq_wd, o_rsp_valid, o_rsp_data, d;
  logic [7:0] rq_fc, o_rsp_exc;
  logic [15:0] rq_a;
  mbsd_tbl_t o_rsp_table;
  logic [5:0] o_rsp_slot;
  logic [3:0] o_rsp_ch;
  mbsd_kind_t o_rsp_kind;
  logic [22:0] rsp_vec, mk;
  logic [22:0] exp_q[$], msk_q[$];
  int error_cnt = 0;
  int total_checks = 0;
  int s, b, a, w;
  assign rsp_vec = {o_rsp_exc, o_rsp_data, o_rsp_table, o_rsp_slot, o_rsp_ch, o_rsp_kind};
  always #4 i_clk = ~i_clk;
  mbsd_master mst (.i_clk(i_clk), .o_valid(rq_v), .o_fc(rq_fc), .o_addr(rq_a),
    .o_ref(rq_ref), .o_wr(rq_wr), .o_wdata(rq_wd));
  mbsd_core #(.ALLOC_BYTES(64)) DUT (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_req_valid(rq_v),
    .i_req_fc(rq_fc), .i_req_addr(rq_a), .i_req_ref_mode(rq_ref), .i_req_wr(rq_wr),
    .i_req_wdata(rq_wd), .i_alloc_we(i_alloc_we), .i_alloc_coil(i_alloc_coil),
    .i_alloc_idx(i_alloc_idx), .i_alloc_ent(i_alloc_ent), .i_din(i_din), .i_mstat(i_mstat),
    .o_rsp_valid(o_rsp_valid), .o_rsp_exc(o_rsp_exc), .o_rsp_data(o_rsp_data),
    .o_rsp_table(o_rsp_table), .o_rsp_slot(o_rsp_slot), .o_rsp_ch(o_rsp_ch),
    .o_rsp_kind(o_rsp_kind), .o_coil_img(o_coil_img));
  ////////////////////////////////////////////////////////////////////////////
  // slot classes
  function automatic mbsd_kind_t kind_of(input int sl);
    if (sl == 0 || sl == 49) return KIND_COM;
    return (sl == 50) ? KIND_PSU : KIND_IO;
  endfunction : kind_of
  task automatic chk(input logic [22:0] seen, input logic [22:0] want);
    total_checks++;
    if (seen !== want) begin
      error_cnt++;
      $display("MISMATCH %0t seen %h want %h", $time, seen, want);
    end
  endtask : chk
  // note the expected answer, then hand the element to the master
  task automatic op(input logic [7:0] fc, input int ad, input logic rm, input logic wr,
                    input logic dd, input mbsd_tbl_t t, input int sl, input int ch);
    exp_q.push_back({EXC_NONE, dd, t, sl[5:0], ch[3:0], kind_of(sl)});
    msk_q.push_back(M_OK);
    mst.req(fc, ad[15:0], rm, wr, wr ? dd : ~dd);
  endtask : op
  // refused element; a coil value of one is offered so a leak shows
  task automatic ex(input logic [7:0] fc, input int ad, input logic rm, input logic wr,
                    input logic [7:0] e, input mbsd_tbl_t t, input logic tk);
    exp_q.push_back({e, 1'b0, t, 10'h000, KIND_COM});
    msk_q.push_back(tk ? M_EX : M_EF);
    mst.req(fc, ad[15:0], rm, wr, 1'b1);
  endtask : ex
  task automatic alloc(input logic c, input logic [5:0] ix, input mbsd_alloc_t e);
    @(negedge i_clk);
    i_alloc_we = 1'b1;
    i_alloc_coil = c;
    i_alloc_idx = ix;
    i_alloc_ent = e;
    @(negedge i_clk);
    i_alloc_we = 1'b0;
    i_alloc_ent = ~e;
  endtask : alloc
  // image lands on the answer edge, so wait two falling edges after release
  task automatic img_chk();
    mst.idle();
    repeat (2) @(negedge i_clk);
    chk(23'(o_coil_img === cimg), 23'h1);
  endtask : img_chk
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : end_of_test
  // answers leave the queue in order; the falling edge sees settled outputs
  always @(negedge i_clk) begin
    if (o_rsp_valid === 1'b1 && exp_q.size() == 0) begin
      error_cnt++;
      $display("MISMATCH %0t answer without request", $time);
    end else if (o_rsp_valid === 1'b1) begin
      mk = msk_q.pop_front();
      chk(rsp_vec & mk, exp_q.pop_front() & mk);
    end
  end
  // hang guard
  initial begin
    #400000;
    error_cnt++;
    $display("MISMATCH %0t run hung", $time);
    end_of_test();
  end
  // main sequence
  initial begin
    w = $urandom(32'h1ba8f93c);
    for (s = 0; s < NSLOT; s++) begin
      i_din[s] = 16'($urandom);
      i_mstat[s] = 8'($urandom);
    end
    repeat (16) @(negedge i_clk);
    i_rst_b = 1'b1;
    // both halves of every slot; reference mode ignores the code
    for (s = 0; s < NSLOT; s++) begin
      for (b = 0; b < 8; b++) begin
        a = (b < 4) ? 8 * s + b : 8 * (s + 1) + b;
        op(FC_RD_DIN, 1024 + a, 1'b0, 1'b0, i_din[s][b], TBL_DIN, s, b);
        op(FC_RD_HREG, 13001 + a, 1'b1, 1'b0, i_din[s][b], TBL_DIN, s, b);
        op(FC_RD_DIN, 2048 + 8 * s + b, 1'b0, 1'b0, i_mstat[s][b], TBL_DIN, s, b);
        op(FC_DIAG, 14001 + 8 * s + b, 1'b1, 1'b0, i_mstat[s][b], TBL_DIN, s, b);
      end
    end
    for (s = 1; s < 49; s++) begin
      for (b = 0; b < 16; b++) begin
        op(FC_RD_DIN, 5120 + 16 * s + b, 1'b0, 1'b0, i_din[s][b], TBL_DIN, s, b);
        op(FC_WR_COIL, 16001 + 16 * s + b, 1'b1, 1'b0, i_din[s][b], TBL_DIN, s, b);
      end
    end
    $display("input test done");
    // coil writes by single, multiple and reference, random values
    for (s = 1; s < 49; s++) begin
      for (b = 0; b < 8; b++) begin
        a = (b < 4) ? 8 * s + b : 8 * (s + 1) + b;
        d = 1'($urandom);
        w = $urandom_range(2, 0);
        cimg[s][b] = d;
        if (w == 2) op(8'h00, 3001 + a, 1'b1, 1'b1, d, TBL_COIL, s, b);
        else op(w ? FC_WR_COILS : FC_WR_COIL, 1024 + a, 1'b0, 1'b1, d, TBL_COIL, s, b);
      end
    end
    img_chk();
    for (s = 1; s < 49; s++) begin
      for (b = 0; b < 8; b++) begin
        a = (b < 4) ? 8 * s + b : 8 * (s + 1) + b;
        op(FC_RD_COIL, 1024 + a, 1'b0, 1'b0, cimg[s][b], TBL_COIL, s, b);
        op(FC_RD_IREG, 3001 + a, 1'b1, 1'b0, cimg[s][b], TBL_COIL, s, b);
      end
    end
    mst.idle();
    $display("coil test done");
    // allocated areas follow the stored entries
    alloc(1'b0, 6'd0, {1'b1, 1'b0, 6'd3});
    alloc(1'b0, 6'd1, {1'b1, 1'b1, 6'd7});
    alloc(1'b0, 6'd4, {1'b1, 1'b0, 6'd51});
    alloc(1'b1, 6'd2, {1'b1, 1'b0, 6'd5});
    for (b = 0; b < 8; b++) begin
      op(FC_RD_DIN, b, 1'b0, 1'b0, i_din[3][b], TBL_DIN, 3, b);
      op(FC_RD_COIL, 10009 + b, 1'b1, 1'b0, i_din[7][8 + b], TBL_DIN, 7, 8 + b);
      op(FC_WR_HREG, 17 + b, 1'b1, 1'b0, cimg[5][b], TBL_COIL, 5, b);
      d = 1'($urandom);
      cimg[5][b] = d;
      op(FC_WR_COILS, 16 + b, 1'b0, 1'b1, d, TBL_COIL, 5, b);
      ex(FC_RD_DIN, 32 + b, 1'b0, 1'b0, EXC_ADDR, TBL_DIN, 1'b1);
    end
    img_chk();
    $display("alloc test done");
    // refused codes and unmapped places leave the coils alone
    ex(FC_DIAG, 1024, 1'b0, 1'b0, EXC_FUNC, TBL_DIN, 1'b0);
    ex(8'h07, 0, 1'b0, 1'b0, EXC_FUNC, TBL_DIN, 1'b0);
    ex(FC_RD_IREG, 0, 1'b0, 1'b0, EXC_ADDR, TBL_IREG, 1'b1);
    ex(FC_RD_HREG, 65535, 1'b0, 1'b0, EXC_ADDR, TBL_HREG, 1'b1);
    ex(FC_WR_HREG, 0, 1'b0, 1'b0, EXC_ADDR, TBL_HREG, 1'b1);
    ex(FC_WR_HREGS, 2, 1'b0, 1'b0, EXC_ADDR, TBL_HREG, 1'b1);
    ex(FC_RD_DIN, 65535, 1'b0, 1'b0, EXC_ADDR, TBL_DIN, 1'b1);
    ex(FC_RD_COIL, 65535, 1'b0, 1'b0, EXC_ADDR, TBL_COIL, 1'b1);
    ex(FC_RD_DIN, 5120 + 5, 1'b0, 1'b0, EXC_ADDR, TBL_DIN, 1'b1);
    ex(FC_RD_COIL, 1026, 1'b0, 1'b0, EXC_ADDR, TBL_COIL, 1'b1);
    ex(FC_RD_DIN, 5120 + 16 * 49, 1'b0, 1'b0, EXC_ADDR, TBL_DIN, 1'b1);
    ex(FC_RD_DIN, 24, 1'b0, 1'b0, EXC_ADDR, TBL_DIN, 1'b1);
    ex(FC_RD_DIN, 512, 1'b0, 1'b0, EXC_ADDR, TBL_DIN, 1'b1);
    ex(FC_WR_COIL, 1027, 1'b0, 1'b1, EXC_ADDR, TBL_COIL, 1'b1);
    ex(FC_RD_COIL, 1024 + 8 * 49, 1'b0, 1'b0, EXC_ADDR, TBL_COIL, 1'b1);
    ex(8'h00, 0, 1'b1, 1'b1, EXC_ADDR, TBL_COIL, 1'b1);
    ex(8'h00, 10000, 1'b1, 1'b0, EXC_ADDR, TBL_DIN, 1'b1);
    ex(8'h00, 20000, 1'b1, 1'b0, EXC_ADDR, TBL_DIN, 1'b0);
    ex(8'h00, 13001, 1'b1, 1'b1, EXC_FUNC, TBL_DIN, 1'b0);
    ex(8'h00, 30000, 1'b1, 1'b0, EXC_ADDR, TBL_IREG, 1'b1);
    ex(8'h00, 49999, 1'b1, 1'b1, EXC_ADDR, TBL_HREG, 1'b1);
    img_chk();
    $display("exception test done");
    for (b = 0; b < 20 && exp_q.size() > 0; b++) @(negedge i_clk);
    if (exp_q.size() > 0) begin
      error_cnt++;
      $display("MISMATCH %0t answers missing", $time);
    end
    end_of_test();
  end
endmodule : test_modbus_slot_address_decoder
